// File: common/block_move_pkg.sv
/*
 Shared definitions for the block move and search unit: opcode bytes,
 state codes, operation kinds and carrier structs.
 Assumes a byte-wide memory port with a request/ready handshake that may take several cycles.
*/
package block_move_pkg;
	localparam logic [7:0] PREFIX_EXT = 8'hed;
	localparam logic [7:0] OP_COPY_STEP_UP = 8'ha0;
	localparam logic [7:0] OP_COPY_REPEAT_UP = 8'hb0;
	localparam logic [7:0] OP_COPY_STEP_DOWN = 8'ha8;
	localparam logic [7:0] OP_COPY_REPEAT_DOWN = 8'hb8;
	localparam logic [7:0] OP_COMPARE_STEP_UP = 8'ha1;
	localparam logic [7:0] OP_COMPARE_REPEAT_UP = 8'hb1;
	localparam logic [7:0] OP_COMPARE_STEP_DOWN = 8'ha9;
	localparam logic [7:0] OP_COMPARE_REPEAT_DOWN = 8'hb9;
	localparam logic [15:0] PAIR_ONE = 16'h0001;
	localparam logic [15:0] PAIR_ZERO = 16'h0000;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_WRITE = 3'b010,
		ST_UPDATE = 3'b011,
		ST_DONE = 3'b100
	} state_t;

	// Decoded operation
	typedef struct packed
	{
		logic isCompare;
		logic goDown;
		logic repeatOp;
	} op_t;

	// Register pair set loaded by software
	typedef struct packed
	{
		logic [15:0] sourcePointerPair;
		logic [15:0] targetPointerPair;
		logic [15:0] byteCountPair;
	} pairs_t;

	// Memory request toward the processor bus
	typedef struct packed
	{
		logic req;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
endpackage

// File: design/block_move_search_unit.sv
/*
 Block copy and block search execution unit with its opcode decoder.
 Assumes memory answers each request with memReady in some later or the
 same cycle; pairs and accumulator are loaded before start.
*/
// Behaviour
// - Copies read at the source pair, write at the target pair, count in the count pair.
// - A copy step reads one source byte and writes it to the target.
// - Each copy step bumps both pointers and decrements the count.
// - The repeating copy runs until the count reaches zero.
// - Pointers and count are full 16-bit values with no overlap limits.
// - Downward copies decrement both pointers instead.
// - A compare step compares the accumulator to the source byte, flags it, bumps source, decrements count.
// - The repeating compare stops on a match or a zero count.
// - Downward compares decrement the source pointer, count still decrements.
// - Prefix then A1 is compare step up, prefix then B1 compare repeat up.
// - Prefix then A9 is compare step down, prefix then B9 compare repeat down.
`timescale 1ns/1ps
module block_move_search_unit
	import block_move_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [7:0] prefixByte,
	input wire logic [7:0] opcodeByte,
	input wire pairs_t pairsIn,
	input wire logic [7:0] accumulator,
	output mem_req_t memReq,
	input wire logic memReady,
	input wire logic [7:0] memRdata,
	output pairs_t pairsOut,
	output logic busy,
	output logic done,
	output logic illegalOp,
	output logic matchFlag,
	output logic countNonZero
);

	////////////////////////////////////////////////////////////////////
	// Decoder

	op_t decOp;
	logic decValid;

	// Opcode table lookup
	always_comb
	begin
		decOp = '0;
		decValid = 1'b0;
		if (prefixByte == PREFIX_EXT)
		begin
			case (opcodeByte)
				OP_COPY_STEP_UP: begin decOp = 3'b000; decValid = 1'b1; end
				OP_COPY_REPEAT_UP: begin decOp = 3'b001; decValid = 1'b1; end
				OP_COPY_STEP_DOWN: begin decOp = 3'b010; decValid = 1'b1; end
				OP_COPY_REPEAT_DOWN: begin decOp = 3'b011; decValid = 1'b1; end
				OP_COMPARE_STEP_UP: begin decOp = 3'b100; decValid = 1'b1; end
				OP_COMPARE_REPEAT_UP: begin decOp = 3'b101; decValid = 1'b1; end
				OP_COMPARE_STEP_DOWN: begin decOp = 3'b110; decValid = 1'b1; end
				OP_COMPARE_REPEAT_DOWN: begin decOp = 3'b111; decValid = 1'b1; end
				default: decValid = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control

	state_t state_r;
	op_t op_r;
	pairs_t pairs_r;
	logic [7:0] accum_r;
	logic [7:0] data_r;
	logic match_r;
	logic illegal_r;
	logic [15:0] countAfter;
	logic finishNow;

	assign countAfter = pairs_r.byteCountPair - PAIR_ONE;
	assign finishNow = !op_r.repeatOp || countAfter == PAIR_ZERO ||
		(op_r.isCompare && data_r == accum_r);

	// State sequencing
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:
					if (start && decValid)
						state_r <= ST_READ;
				ST_READ:
					if (memReady)
						state_r <= op_r.isCompare ? ST_UPDATE : ST_WRITE;
				ST_WRITE:
					if (memReady)
						state_r <= ST_UPDATE;
				ST_UPDATE:
					state_r <= finishNow ? ST_DONE : ST_READ;
				ST_DONE:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Operation and accumulator capture
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			op_r <= '0;
			accum_r <= 8'h00;
		end
		else if (state_r == ST_IDLE && start && decValid)
		begin
			op_r <= decOp;
			accum_r <= accumulator;
		end
	end

	// Illegal opcode report, one pulse
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			illegal_r <= 1'b0;
		else
			illegal_r <= state_r == ST_IDLE && start && !decValid;
	end

	// Read data capture
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			data_r <= 8'h00;
		else if (state_r == ST_READ && memReady)
			data_r <= memRdata;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			match_r <= 1'b0;
		else if (state_r == ST_UPDATE && op_r.isCompare)
			match_r <= data_r == accum_r;
	end

	// Pointer and counter update, full 16-bit wrap
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			pairs_r <= '0;
		else if (state_r == ST_IDLE && start && decValid)
			pairs_r <= pairsIn;
		else if (state_r == ST_UPDATE)
		begin
			pairs_r.sourcePointerPair <= op_r.goDown ?
				pairs_r.sourcePointerPair - PAIR_ONE :
				pairs_r.sourcePointerPair + PAIR_ONE;
			if (!op_r.isCompare)
				pairs_r.targetPointerPair <= op_r.goDown ?
					pairs_r.targetPointerPair - PAIR_ONE :
					pairs_r.targetPointerPair + PAIR_ONE;
			pairs_r.byteCountPair <= countAfter;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Memory requests

	// read at source, write at target
	always_comb
	begin
		memReq = '0;
		if (state_r == ST_READ)
		begin
			memReq.req = 1'b1;
			memReq.addr = pairs_r.sourcePointerPair;
		end
		else if (state_r == ST_WRITE)
		begin
			memReq.req = 1'b1;
			memReq.write = 1'b1;
			memReq.addr = pairs_r.targetPointerPair;
			memReq.wdata = data_r;
		end
	end

	assign pairsOut = pairs_r;
	assign busy = state_r != ST_IDLE;
	assign done = state_r == ST_DONE;
	assign illegalOp = illegal_r;
	assign matchFlag = match_r;
	assign countNonZero = pairs_r.byteCountPair != PAIR_ZERO;

	////////////////////////////////////////////////////////////////////
	// Checks

	sequence stepUpdate;
		state_r == ST_UPDATE;
	endsequence

	property pointerStep;
		@(posedge core_clk) disable iff (!rst_b)
		stepUpdate |=> pairs_r.sourcePointerPair ==
			($past(op_r.goDown) ? $past(pairs_r.sourcePointerPair) - 16'h0001
			: $past(pairs_r.sourcePointerPair) + 16'h0001);
	endproperty

	source_step_a:
		assert property (pointerStep)
		else $error("source pointer did not step by one");

	count_down_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			stepUpdate |=> pairs_r.byteCountPair ==
			$past(pairs_r.byteCountPair) - 16'h0001)
		else $error("count did not decrement");

	target_move_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			(stepUpdate and (!op_r.isCompare && op_r.goDown)) |=>
			pairs_r.targetPointerPair ==
			$past(pairs_r.targetPointerPair) - 16'h0001)
		else $error("downward target pointer wrong");

	target_up_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			(stepUpdate and (!op_r.isCompare && !op_r.goDown)) |=>
			pairs_r.targetPointerPair ==
			$past(pairs_r.targetPointerPair) + 16'h0001)
		else $error("upward target pointer wrong");

	compare_nowrite_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			state_r == ST_READ && op_r.isCompare && memReady |=>
			state_r == ST_UPDATE)
		else $error("compare step went on to a write");

	copy_write_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			state_r == ST_WRITE |-> memReq.write && memReq.req &&
			memReq.addr == pairs_r.targetPointerPair &&
			memReq.wdata == data_r)
		else $error("copy write malformed");

	read_source_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			state_r == ST_READ |-> !memReq.write &&
			memReq.addr == pairs_r.sourcePointerPair)
		else $error("read not at source pointer");

	repeat_end_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			(stepUpdate and (op_r.repeatOp && !op_r.isCompare &&
			countAfter != 16'h0000)) |=> state_r == ST_READ)
		else $error("copy repeat stopped early");

	search_stop_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			(stepUpdate and (op_r.isCompare && data_r == accum_r)) |=>
			done && matchFlag)
		else $error("search did not stop on match");

	decode_cmp_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			state_r == ST_IDLE && start && prefixByte == 8'hed &&
			opcodeByte == 8'hb1 |=> busy && op_r.isCompare &&
			op_r.repeatOp && !op_r.goDown)
		else $error("compare repeat up not decoded");

	decode_down_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			state_r == ST_IDLE && start && prefixByte == 8'hed &&
			opcodeByte == 8'ha9 |=> op_r == 3'b110)
		else $error("compare step down not decoded");

	decode_copy_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			state_r == ST_IDLE && start && prefixByte == 8'hed &&
			opcodeByte == 8'hb8 |=> op_r == 3'b011)
		else $error("copy repeat down not decoded");

	step_once_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			(stepUpdate and !op_r.repeatOp) |=> done ##1 !busy)
		else $error("single step did not finish");

	illegal_pulse_a:
		assert property (@(posedge core_clk) disable iff (!rst_b)
			state_r == ST_IDLE && start && !decValid |=>
			illegalOp && !busy)
		else $error("unknown opcode not refused");

endmodule // block_move_search_unit

// File: verification/byte_memory_model.sv
/*
 Byte-wide memory answering the unit's request/ready port.
 Assumes one clock; the bench may preload or inspect the array.
*/
`timescale 1ns/1ps
module byte_memory_model
	import block_move_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire mem_req_t memReq,
	input wire logic [1:0] waitCycles,
	output logic memReady,
	output logic [7:0] memRdata
);
	logic [7:0] mem [0:65535];
	logic [1:0] waitCnt_r;
	logic [7:0] lastRd_r;
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	// Ready after the chosen wait, read data only with it
	assign memReady = memReq.req && (waitCnt_r == waitCycles);
	assign memRdata = (memReady && !memReq.write) ? mem[memReq.addr]
		: ~lastRd_r;
	// Wait counter and toggling idle data
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			waitCnt_r <= 2'd0;
			lastRd_r <= 8'h00;
		end
		else
		begin
			waitCnt_r <= (memReq.req && !memReady) ? waitCnt_r + 2'd1 : 2'd0;
			lastRd_r <= memRdata;
		end
	end
	// Accepted writes
	always @(posedge core_clk)
	begin
		if (memReady && memReq.write)
			mem[memReq.addr] <= memReq.wdata;
	end
endmodule // byte_memory_model

// File: verification/test_block_move_search_unit.sv
/*
 Self-checking bench for the block copy and search unit.
 Assumes the byte memory model on the far side.
*/
`timescale 1ns/1ps
module test_block_move_search_unit import block_move_pkg::*;;
	logic core_clk, rst_b, start, memReady, busy, done;
	logic illegalOp, matchFlag, countNonZero;
	logic [7:0] prefixByte, opcodeByte, accumulator, memRdata;
	logic [1:0] waitCycles;
	pairs_t pairsIn, pairsOut;
	mem_req_t memReq;
	int errors, nCompared;
	block_move_search_unit dut_u (.core_clk(core_clk), .rst_b(rst_b),
		.start(start), .prefixByte(prefixByte), .opcodeByte(opcodeByte),
		.pairsIn(pairsIn), .accumulator(accumulator), .memReq(memReq),
		.memReady(memReady), .memRdata(memRdata), .pairsOut(pairsOut),
		.busy(busy), .done(done), .illegalOp(illegalOp),
		.matchFlag(matchFlag), .countNonZero(countNonZero));
	byte_memory_model mem_u (.core_clk(core_clk), .rst_b(rst_b),
		.memReq(memReq), .waitCycles(waitCycles), .memReady(memReady),
		.memRdata(memRdata));
	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [47:0] seen,
		input logic [47:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && nCompared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One instruction from start to done
	task automatic run(input logic [7:0] op, input logic [15:0] s, t, c,
		input logic [7:0] acc, input logic [1:0] w);
		int n;
		n = 0;
		@(posedge core_clk);
		start <= 1'b1;
		opcodeByte <= op;
		pairsIn <= {s, t, c};
		accumulator <= acc;
		waitCycles <= w;
		@(posedge core_clk);
		start <= 1'b0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (done !== 1'b1 && n < 1000);
		check("done seen", 48'(n < 1000), 48'h1);
		@(negedge core_clk);
		check("done and busy low", {46'h0, done, busy}, 48'h0);
	endtask
	task automatic copy_up;
		mem_u.mem[16'h1000] = 8'hc3;
		run(OP_COPY_STEP_UP, 16'h1000, 16'h2000, 16'h0003, 8'h00, 2'd2);
		check("copied", 48'(mem_u.mem[16'h2000]), 48'hc3);
		check("pairs", pairsOut, {16'h1001, 16'h2001, 16'h0002});
		check("count flag", 48'(countNonZero), 48'h1);
	endtask
	task automatic copy_overlap;
		logic [7:0] e [0:5];
		for (int i = 0; i < 6; i++)
		begin
			e[i] = 8'h30 + 8'(i);
			mem_u.mem[16'h0010 + 16'(i)] = e[i];
		end
		for (int i = 0; i < 4; i++)
			e[i + 2] = e[i];
		run(OP_COPY_REPEAT_UP, 16'h0010, 16'h0012, 16'h0004, 8'h00, 2'd0);
		for (int i = 0; i < 6; i++)
			check("overlap", 48'(mem_u.mem[16'h0010 + 16'(i)]), 48'(e[i]));
		check("pairs", pairsOut, {16'h0014, 16'h0016, 16'h0000});
	endtask
	task automatic copy_down;
		mem_u.mem[16'h0300] = 8'h5c;
		mem_u.mem[16'h0001] = 8'h11;
		mem_u.mem[16'h0000] = 8'h22;
		run(OP_COPY_STEP_DOWN, 16'h0300, 16'h0400, 16'h0001, 8'h00, 2'd1);
		check("copied", 48'(mem_u.mem[16'h0400]), 48'h5c);
		check("pairs", pairsOut, {16'h02ff, 16'h03ff, 16'h0000});
		check("count flag", 48'(countNonZero), 48'h0);
		run(OP_COPY_REPEAT_DOWN, 16'h0001, 16'hffff, 16'h0003, 8'h00, 2'd1);
		check("wrap", {24'h0, mem_u.mem[16'hffff], mem_u.mem[16'hfffe],
			mem_u.mem[16'hfffd]}, 48'h112211);
		check("pairs", pairsOut, {16'hfffe, 16'hfffc, 16'h0000});
	endtask
	task automatic compare_up;
		mem_u.mem[16'h0502] = 8'h5a;
		run(OP_COMPARE_REPEAT_UP, 16'h0500, 16'h1234, 16'h0005, 8'h5a, 2'd2);
		check("pairs", pairsOut, {16'h0503, 16'h1234, 16'h0002});
		check("match", 48'(matchFlag), 48'h1);
		run(OP_COMPARE_STEP_UP, 16'h0700, 16'h1234, 16'h0002, 8'h5a, 2'd0);
		check("pairs", pairsOut, {16'h0701, 16'h1234, 16'h0001});
		check("match", 48'(matchFlag), 48'h0);
	endtask
	task automatic compare_down;
		mem_u.mem[16'h0800] = 8'h77;
		run(OP_COMPARE_STEP_DOWN, 16'h0800, 16'h4321, 16'h0004, 8'h77, 2'd1);
		check("pairs", pairsOut, {16'h07ff, 16'h4321, 16'h0003});
		check("match", 48'(matchFlag), 48'h1);
		run(OP_COMPARE_REPEAT_DOWN, 16'h0600, 16'h4321, 16'h0003, 8'h77, 2'd0);
		check("pairs", pairsOut, {16'h05fd, 16'h4321, 16'h0000});
		check("match", 48'(matchFlag), 48'h0);
	endtask
	task automatic bad_opcode;
		int hits;
		for (int k = 0; k < 2; k++)
		begin
			hits = 0;
			@(posedge core_clk);
			start <= 1'b1;
			prefixByte <= (k == 0) ? PREFIX_EXT : 8'h00;
			opcodeByte <= (k == 0) ? 8'h44 : OP_COPY_STEP_UP;
			@(posedge core_clk);
			start <= 1'b0;
			prefixByte <= PREFIX_EXT;
			repeat (3)
			begin
				@(negedge core_clk);
				if (illegalOp === 1'b1)
					hits++;
				if (busy !== 1'b0)
					hits += 10;
			end
			check("refused opcode", 48'(hits), 48'h1);
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge core_clk);
		errors++;
		tally_and_finish;
	end
	initial
	begin
		rst_b = 1'b0;
		start = 1'b0;
		prefixByte = PREFIX_EXT;
		opcodeByte = 8'h00;
		pairsIn = '0;
		accumulator = 8'h00;
		waitCycles = 2'd0;
		errors = 0;
		nCompared = 0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		copy_up;
		copy_overlap;
		copy_down;
		compare_up;
		compare_down;
		bad_opcode;
		tally_and_finish;
	end
endmodule // test_block_move_search_unit
